// >>> design/ppm_cfg.svh
// Constants for the printer port pin mapping block: offsets, bit positions,
// reset values and response codes.
// Assumes it is included by bare name wherever these names are needed.
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// Register byte offsets on the AXI4-Lite bus.
`define PPM_OFF_DATA 8'h00
`define PPM_OFF_STATUS 8'h04
`define PPM_OFF_CONTROL 8'h08

// Status register bit positions.
`define PPM_ST_FAULT 3
`define PPM_ST_ONLINE 4
`define PPM_ST_PAPER 5
`define PPM_ST_ACK 6

// Control register bit positions.
`define PPM_CT_STROBE 0
`define PPM_CT_ALF 1
`define PPM_CT_INIT 2
`define PPM_CT_SELECT 3
`define PPM_CT_DIR 5

// Reset values: initialise output high, all else zero.
`define PPM_CTRL_RST 8'h04
`define PPM_DATA_RST 8'h00

// AXI response codes.
`define PPM_RESP_OKAY 2'h0
`define PPM_RESP_SLVERR 2'h2

`endif

// >>> design/ppm_pkg.sv
// Types shared by the printer port pin mapping block.
// Assumes nothing of its surroundings.
package ppm_pkg;
	// One byte of port data or of a register.
	typedef logic [7:0] ppm_byte_t;
	// Bus address, byte granular.
	typedef logic [7:0] ppm_addr_t;
	// AXI response code.
	typedef logic [1:0] ppm_resp_t;
	// Which register an address selects.
	typedef enum logic [1:0] {PPM_SEL_DATA, PPM_SEL_STATUS, PPM_SEL_CONTROL, PPM_SEL_NONE} ppm_sel_e;
endpackage : ppm_pkg

// >>> design/ppm_port.sv
// Printer port pin mapping: AXI4-Lite registers that map onto printer pins.
// Assumes one 100 MHz clock, inputs synchronous to it, and a bus master
// that keeps at most one write and one read under way at a time.
//
// Operation
// RULE1 - Status bit 6 reads acknowledge input level.
// RULE2 - Status bit 3 reads printer fault input.
// RULE3 - Select output is inverse of control bit 3.
// RULE4 - Initialise output follows control bit 2 directly.
// RULE5 - Auto line feed is inverse of bit 1.
// RULE6 - Data strobe is inverse of bit 0.
// RULE7 - Status bit 4 reads printer online input.
// RULE8 - Status bit 5 reads paper empty input.
// RULE9 - Eight bidirectional data lines carry one byte.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "ppm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ppm_port
(
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite write address channel.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire ppm_pkg::ppm_addr_t s_axi_awaddr,
	// AXI4-Lite write data channel.
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response channel.
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output ppm_pkg::ppm_resp_t s_axi_bresp,
	// AXI4-Lite read address channel.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire ppm_pkg::ppm_addr_t s_axi_araddr,
	// AXI4-Lite read data channel.
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output ppm_pkg::ppm_resp_t s_axi_rresp,
	// Printer status inputs.
	input wire logic printer_ack_n_in,
	input wire logic printer_fault_n_in,
	input wire logic printer_online_in,
	input wire logic paper_empty_in,
	// Printer control outputs.
	output logic printer_select_out,
	output logic printer_init_out,
	output logic auto_line_feed_out,
	output logic data_strobe_out,
	// Bidirectional port data, split into three signals.
	input wire ppm_pkg::ppm_byte_t port_data_in,
	output ppm_pkg::ppm_byte_t port_data_out,
	output ppm_pkg::ppm_byte_t port_data_oe_n
);
	import ppm_pkg::*;

	// Maps a byte address onto a register; anything else is unmapped.
	function automatic ppm_sel_e ppm_decode(input ppm_addr_t addr);
		ppm_sel_e sel;
		sel = PPM_SEL_NONE;
		if (addr == `PPM_OFF_DATA)
		begin
			sel = PPM_SEL_DATA;
		end
		else if (addr == `PPM_OFF_STATUS)
		begin
			sel = PPM_SEL_STATUS;
		end
		else if (addr == `PPM_OFF_CONTROL)
		begin
			sel = PPM_SEL_CONTROL;
		end
		return sel;
	endfunction : ppm_decode

	// Write channel state: captured address and data, held until both arrive.
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	ppm_addr_t aw_addr_reg, aw_addr_next;
	ppm_byte_t w_data_reg, w_data_next;
	logic w_lane0_reg, w_lane0_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	ppm_resp_t bresp_reg, bresp_next;
	// Software visible registers.
	ppm_byte_t ctrl_reg, ctrl_next;
	ppm_byte_t dout_reg, dout_next;
	// Pin drivers, each a flip-flop of its own.
	logic select_reg, select_next;
	logic init_reg, init_next;
	logic alf_reg, alf_next;
	logic strobe_reg, strobe_next;
	ppm_byte_t oe_n_reg, oe_n_next;
	// Read channel state.
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	ppm_resp_t rresp_reg, rresp_next;
	// Live status byte built from the printer inputs.
	ppm_byte_t status_now;
	// Handshake terms.
	logic aw_fire, w_fire, ar_fire, do_write;
	ppm_sel_e wsel;

	// Status bits are the raw pin levels; low-active pins are not inverted.
	always_comb
	begin
		status_now = 8'h00;
		status_now[`PPM_ST_ACK] = printer_ack_n_in; // RULE1
		status_now[`PPM_ST_FAULT] = printer_fault_n_in; // RULE2
		status_now[`PPM_ST_ONLINE] = printer_online_in; // RULE7
		status_now[`PPM_ST_PAPER] = paper_empty_in; // RULE8
	end

	// Write path: address and data may come in either order.
	always_comb
	begin
		aw_fire = s_axi_awvalid && awready_reg;
		w_fire = s_axi_wvalid && wready_reg;
		aw_got_next = aw_got_reg || aw_fire;
		w_got_next = w_got_reg || w_fire;
		aw_addr_next = aw_fire ? s_axi_awaddr : aw_addr_reg;
		w_data_next = w_fire ? s_axi_wdata[7:0] : w_data_reg;
		w_lane0_next = w_fire ? s_axi_wstrb[0] : w_lane0_reg;
		// The write happens once both halves are held.
		do_write = aw_got_reg && w_got_reg && !bvalid_reg;
		wsel = ppm_decode(aw_addr_reg);
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		dout_next = dout_reg;
		if (do_write)
		begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wsel == PPM_SEL_NONE) ? `PPM_RESP_SLVERR : `PPM_RESP_OKAY;
			// Only byte lane 0 carries data; a write without it changes nothing.
			if (w_lane0_reg && wsel == PPM_SEL_CONTROL)
			begin
				ctrl_next = w_data_reg;
			end
			else if (w_lane0_reg && wsel == PPM_SEL_DATA)
			begin
				dout_next = w_data_reg;
			end
		end
		else if (bvalid_reg && s_axi_bready)
		begin
			bvalid_next = 1'b0;
		end
		// Ready drops after each take so a second item waits for the response.
		awready_next = !aw_got_next && !bvalid_next;
		wready_next = !w_got_next && !bvalid_next;
	end

	// Pin drivers follow the next control value so they change with it.
	always_comb
	begin
		select_next = !ctrl_next[`PPM_CT_SELECT]; // RULE3
		init_next = ctrl_next[`PPM_CT_INIT]; // RULE4
		alf_next = !ctrl_next[`PPM_CT_ALF]; // RULE5
		strobe_next = !ctrl_next[`PPM_CT_STROBE]; // RULE6
		// Direction bit set turns the data lines round to receive.
		oe_n_next = {8{ctrl_next[`PPM_CT_DIR]}}; // RULE9
	end

	// Read path: one read at a time, answered one cycle after the take.
	always_comb
	begin
		ar_fire = s_axi_arvalid && arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (ar_fire)
		begin
			rvalid_next = 1'b1;
			rresp_next = `PPM_RESP_OKAY;
			unique case (ppm_decode(s_axi_araddr))
				PPM_SEL_DATA: rdata_next = {24'h000000, port_data_in}; // RULE9
				PPM_SEL_STATUS: rdata_next = {24'h000000, status_now};
				PPM_SEL_CONTROL: rdata_next = {24'h000000, ctrl_reg};
				PPM_SEL_NONE:
				begin
					rdata_next = 32'h00000000;
					rresp_next = `PPM_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// All state registers; reset gives constants only.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_lane0_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `PPM_RESP_OKAY;
			ctrl_reg <= `PPM_CTRL_RST;
			dout_reg <= `PPM_DATA_RST;
			select_reg <= 1'b1;
			init_reg <= 1'b1;
			alf_reg <= 1'b1;
			strobe_reg <= 1'b1;
			oe_n_reg <= 8'h00;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `PPM_RESP_OKAY;
		end
		else
		begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_lane0_reg <= w_lane0_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			ctrl_reg <= ctrl_next;
			dout_reg <= dout_next;
			select_reg <= select_next;
			init_reg <= init_next;
			alf_reg <= alf_next;
			strobe_reg <= strobe_next;
			oe_n_reg <= oe_n_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// Every output is a flip-flop.
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign printer_select_out = select_reg;
	assign printer_init_out = init_reg;
	assign auto_line_feed_out = alf_reg;
	assign data_strobe_out = strobe_reg;
	assign port_data_out = dout_reg;
	assign port_data_oe_n = oe_n_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// A status read is taken, then its data comes back next cycle.
	sequence status_read_s;
		ar_fire && ppm_decode(s_axi_araddr) == PPM_SEL_STATUS;
	endsequence

	// Both write halves held marks the write cycle.
	sequence write_ready_s;
		aw_got_reg && w_got_reg && !bvalid_reg;
	endsequence

	chk_status_ack: assert property (status_read_s |=> // RULE1
		s_axi_rdata[`PPM_ST_ACK] == $past(printer_ack_n_in))
		else $error("Status bit 6 does not match acknowledge input.");
	chk_status_fault: assert property (status_read_s |=> // RULE2
		s_axi_rdata[`PPM_ST_FAULT] == $past(printer_fault_n_in))
		else $error("Status bit 3 does not match fault input.");
	chk_select_inverse: assert property (printer_select_out == !ctrl_reg[`PPM_CT_SELECT]) // RULE3
		else $error("Select output is not the inverse of control bit 3.");
	chk_init_follow: assert property (printer_init_out == ctrl_reg[`PPM_CT_INIT]) // RULE4
		else $error("Initialise output does not follow control bit 2.");
	chk_alf_inverse: assert property (auto_line_feed_out == !ctrl_reg[`PPM_CT_ALF]) // RULE5
		else $error("Auto line feed is not the inverse of control bit 1.");
	chk_strobe_inverse: assert property (data_strobe_out == !ctrl_reg[`PPM_CT_STROBE]) // RULE6
		else $error("Strobe output is not the inverse of control bit 0.");
	chk_status_online: assert property (status_read_s |=> // RULE7
		s_axi_rdata[`PPM_ST_ONLINE] == $past(printer_online_in))
		else $error("Status bit 4 does not match online input.");
	chk_status_paper: assert property (status_read_s |=> // RULE8
		s_axi_rdata[`PPM_ST_PAPER] == $past(paper_empty_in))
		else $error("Status bit 5 does not match paper empty input.");
	chk_data_drive: assert property (port_data_oe_n == {8{ctrl_reg[`PPM_CT_DIR]}} // RULE9
		&& port_data_out == dout_reg)
		else $error("Data lines are not driven from the data register.");
	chk_write_resp: assert property (write_ready_s |=> s_axi_bvalid ##0 !s_axi_awready)
		else $error("Write response did not follow both halves.");
endmodule : ppm_port

`default_nettype wire

// >>> dv/ppm_printer.sv
// Behavioural printer on the far side of the parallel port pins.
// Assumes the port's strobe and data lines share the bench clock.
`timescale 1ns/1ps
`default_nettype none
module ppm_printer
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe_n,
	input wire logic [7:0] dev_data,
	input wire logic [7:0] dev_oe_n,
	input wire logic [7:0] reply,
	output logic [7:0] lines,
	output logic ack_n,
	output logic [7:0] got
);
	// A line shows the device's bit while it drives, else the printer's bit.
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			lines[i] = dev_oe_n[i] ? reply[i] : dev_data[i];
		end
	end
	// The byte is taken once per strobe, so a long strobe cannot retake a changed bus.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_n <= 1'h1;
			got <= 8'h00;
		end
		else
		begin
			if (!strobe_n && ack_n)
			begin
				got <= lines;
			end
			ack_n <= strobe_n;
		end
	end
endmodule : ppm_printer
`default_nettype wire

// >>> dv/ppm_port_tb.sv
// Self-checking bench for the printer port pin mapping block.
// Assumes the design files and the printer model are compiled first.
`include "ppm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ppm_port_tb;
	import ppm_pkg::*;
	logic clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic ack_n, flt_n, onl, pap, sel, ini, alf, stb;
	ppm_addr_t awa, ara;
	logic [31:0] wd, rd;
	ppm_resp_t bresp, rresp, r;
	ppm_byte_t pout, poe_n, lines, reply, got;
	logic [31:0] v;
	// Write strobes, all lanes on except in the masked write test.
	logic [3:0] ws;
	int n_fail, checks;
	// Rows: control byte, then select, init, line feed and strobe pin levels.
	logic [11:0] rows [5] = '{12'h00B, 12'h0F4, 12'h05E, 12'h0A1, 12'h04F};
	ppm_port u_ppm_port (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .printer_ack_n_in(ack_n),
		.printer_fault_n_in(flt_n), .printer_online_in(onl), .paper_empty_in(pap),
		.printer_select_out(sel), .printer_init_out(ini), .auto_line_feed_out(alf),
		.data_strobe_out(stb), .port_data_in(lines), .port_data_out(pout), .port_data_oe_n(poe_n));
	ppm_printer u_ppm_printer (.clk(clk), .rst_n(rst_n), .strobe_n(stb), .dev_data(pout),
		.dev_oe_n(poe_n), .reply(reply), .lines(lines), .ack_n(ack_n), .got(got));
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Counts a comparison and reports a difference at once.
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// A wait that runs out of cycles ends the run as a failure.
	task automatic spent(input int n);
		if (n > 50)
		begin
			n_fail++;
			print_verdict();
		end
	endtask : spent
	// Write cycle: both halves offered together, each dropped when taken.
	task automatic axw(input ppm_addr_t a, input logic [31:0] d);
		int n;
		awv <= 1'h1;
		wv <= 1'h1;
		awa <= a;
		wd <= d;
		br <= 1'h1;
		// An unknown response valid must not pass for an answer.
		for (n = 0; n <= 50 && bv !== 1'h1; n++)
		begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end
		spent(n);
		r = bresp;
		br <= 1'h0;
		@(posedge clk);
	endtask : axw
	// Read cycle: address held until taken, data taken at the rvalid edge.
	task automatic axr(input ppm_addr_t a);
		int n;
		arv <= 1'h1;
		ara <= a;
		rr <= 1'h1;
		for (n = 0; n <= 50 && rv !== 1'h1; n++)
		begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end
		spent(n);
		v = rd;
		r = rresp;
		rr <= 1'h0;
		@(posedge clk);
	endtask : axr
	initial
	begin
		n_fail = 0;
		checks = 0;
		rst_n = 1'h0;
		awv = 1'h0;
		wv = 1'h0;
		br = 1'h0;
		arv = 1'h0;
		rr = 1'h0;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		ws = 4'hF;
		reply = 8'h3C;
		flt_n = 1'h1;
		onl = 1'h1;
		pap = 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk({sel, ini, alf, stb, poe_n}, 12'hF00, "reset pins");
		axr(`PPM_OFF_CONTROL);
		chk(v, 32'h4, "control reset");
		foreach (rows[i])
		begin
			axw(`PPM_OFF_CONTROL, {24'h0, rows[i][11:4]});
			chk({sel, ini, alf, stb}, rows[i][3:0], "pins");
			chk(r, `PPM_RESP_OKAY, "write response");
		end
		$display("control pin rows done");
		for (int k = 0; k < 8; k++)
		begin
			{flt_n, onl, pap} <= k[2:0];
			@(posedge clk);
			axr(`PPM_OFF_STATUS);
			chk(v, (32'h40 | k[2] << `PPM_ST_FAULT | k[1] << `PPM_ST_ONLINE
				| k[0] << `PPM_ST_PAPER), "status");
			chk(r, `PPM_RESP_OKAY, "read response");
		end
		$display("status rows done");
		axw(`PPM_OFF_DATA, 32'hA5);
		chk(pout, 8'hA5, "data pins");
		axw(`PPM_OFF_CONTROL, 32'h05);
		axr(`PPM_OFF_STATUS);
		chk(v[6], 1'h0, "ack low");
		chk(got, 8'hA5, "printer byte");
		axw(`PPM_OFF_CONTROL, 32'h24);
		axr(`PPM_OFF_STATUS);
		chk(v[6], 1'h1, "ack high");
		axr(`PPM_OFF_DATA);
		chk(poe_n, 8'hFF, "released lines");
		chk(v, 32'h3C, "line levels read back");
		axw(8'h0C, 32'h1);
		chk(r, `PPM_RESP_SLVERR, "unmapped write");
		axr(8'h0C);
		chk(r, `PPM_RESP_SLVERR, "unmapped read response");
		chk(v, 32'h0, "unmapped read data");
		$display("strobe, direction and unmapped tests done");
		// Writes that must leave the control register as it stands.
		axw(`PPM_OFF_STATUS, 32'hFF);
		chk(r, `PPM_RESP_OKAY, "status write response");
		ws <= 4'hE;
		axw(`PPM_OFF_CONTROL, 32'h0B);
		ws <= 4'hF;
		chk(r, `PPM_RESP_OKAY, "masked write response");
		axr(`PPM_OFF_CONTROL);
		chk(v, 32'h24, "masked write ignored");
		chk({sel, ini, alf, stb}, 4'hF, "pins after masked write");
		// A reset in mid-run must bring the four control pins and the data line enables back to their idle levels.
		axw(`PPM_OFF_CONTROL, 32'h2B);
		chk({sel, ini, alf, stb, poe_n}, 12'h0FF, "pins before reset");
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk({sel, ini, alf, stb, poe_n}, 12'hF00, "pins after reset");
		axr(`PPM_OFF_CONTROL);
		chk(v, 32'h4, "control after reset");
		$display("masked write and mid-run reset tests done");
		print_verdict();
	end
endmodule : ppm_port_tb
`default_nettype wire
